// ==== logic/ssm_consts.svh ====
`ifndef SSM_CONSTS_SVH
`define SSM_CONSTS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define SSM_CLK_HZ 20000000
`define SSM_GAP_NS 2000
`define SSM_GAP_CYC ((`SSM_GAP_NS * (`SSM_CLK_HZ / 1000000) + 999) / 1000)
`define SSM_POR_HOLD_CYC 16

// ----------------------------------------
// Frame and register layout
// ----------------------------------------
`define SSM_FRAME_BITS 16
`define SSM_CTRL_W 16
`define SSM_STAT_W 16
`define SSM_CTRL_RST 16'h0000
`define SSM_STAT_RST 16'h0000
`define SSM_CTRL_GATE_EN 0
`define SSM_STAT_MOTOR_LOW 15

`endif

// ==== logic/ssm_pkg.sv ====
package ssm_pkg;
    typedef enum logic [1:0] {
        SSM_POR,
        SSM_STANDBY,
        SSM_ACTIVE
    } ssm_mode_t;
endpackage

// ==== logic/ssm_gap_timer.sv ====
`timescale 1ns/10ps
`include "ssm_consts.svh"

module ssm_gap_timer #(
    parameter int GAP_CYC = `SSM_GAP_CYC,
    parameter int CNT_W = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Select line, high between frames
    input wire logic selectHigh,
    // Gap long enough
    output logic gapMet
);
    logic [CNT_W-1:0] count_q;

    // Saturating count of idle cycles; restarts at every frame
    always_ff @(posedge clk) begin
        if (rst || !selectHigh) begin
            count_q <= '0;
        end else if (count_q != CNT_W'(GAP_CYC)) begin
            count_q <= count_q + CNT_W'(1);
        end
    end

    assign gapMet = (count_q == CNT_W'(GAP_CYC));
endmodule

// ==== logic/ssm_mode_ctrl.sv ====
`timescale 1ns/10ps
`include "ssm_consts.svh"

module ssm_mode_ctrl #(
    parameter int FRAME_BITS = `SSM_FRAME_BITS,
    parameter int POR_HOLD_CYC = `SSM_POR_HOLD_CYC,
    parameter int GAP_CYC = `SSM_GAP_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supply comparators and enable pin
    input wire logic logicSupplyAboveRelease,
    input wire logic logicSupplyBelowDrop,
    input wire logic motorSupplyOk,
    input wire logic enablePin,
    // Serial link
    input wire logic select_low_n,
    input wire logic serialClk,
    input wire logic serialIn,
    output logic serialOut,
    output logic serialOutOen_n,
    // Fault events from diagnostics
    input wire logic [`SSM_STAT_W-1:0] faultEvent,
    // Mode and drive outputs
    output ssm_pkg::ssm_mode_t mode,
    output logic gateEnable,
    output logic chargePumpEn,
    output logic diagEnable,
    output logic cmdAccepted,
    output logic gapViolation,
    output logic [`SSM_CTRL_W-1:0] ctrlWord,
    output logic [`SSM_STAT_W-1:0] statusWord
);
    import ssm_pkg::*;

    // ----------------------------------------
    // Supply tracking and mode
    // ----------------------------------------
    localparam int HOLD_W = $clog2(POR_HOLD_CYC + 1);
    localparam int BIT_W = $clog2(FRAME_BITS + 1);

    ssm_mode_t mode_q;
    ssm_mode_t mode_d;
    logic supplyValid_q;
    logic [HOLD_W-1:0] porCount_q;
    logic clearAll_q;
    logic porDone;

    // Hysteresis between the release and drop levels
    always_ff @(posedge clk) begin
        if (rst) begin
            supplyValid_q <= 1'b0;
        end else if (logicSupplyBelowDrop) begin
            supplyValid_q <= 1'b0;
        end else if (logicSupplyAboveRelease) begin
            supplyValid_q <= 1'b1;
        end
    end

    // Internal reset stretched after the supply becomes valid
    always_ff @(posedge clk) begin
        if (rst || !supplyValid_q) begin
            porCount_q <= '0;
        end else if (!porDone) begin
            porCount_q <= porCount_q + HOLD_W'(1);
        end
    end

    assign porDone = (porCount_q == HOLD_W'(POR_HOLD_CYC));

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            SSM_POR: begin
                if (porDone) begin
                    mode_d = SSM_STANDBY;
                end
            end
            SSM_STANDBY: begin
                // Leaves standby only once the clear has been released
                if (porDone && enablePin && !clearAll_q) begin
                    mode_d = SSM_ACTIVE;
                end
            end
            SSM_ACTIVE: begin
                if (!enablePin) begin
                    mode_d = SSM_STANDBY;
                end
            end
            default: begin
                mode_d = SSM_POR;
            end
        endcase
        if (!supplyValid_q || !porDone) begin
            mode_d = SSM_POR;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= SSM_POR;
        end else begin
            mode_q <= mode_d;
        end
    end

    // Registered clear; being a flop it cannot glitch into the async clears below
    always_ff @(posedge clk) begin
        if (rst) begin
            clearAll_q <= 1'b1;
        end else begin
            // Released one cycle ahead of active so the mode change sees the clear already gone
            clearAll_q <= !((mode_d == SSM_ACTIVE) || (mode_d == SSM_STANDBY && enablePin));
        end
    end

    // ----------------------------------------
    // Serial frame capture
    // ----------------------------------------
    logic [`SSM_CTRL_W-1:0] ctrl_q;
    logic [`SSM_STAT_W-1:0] status_q;
    logic [`SSM_STAT_W-1:0] statSet;
    logic sclkPrev_q;
    logic selPrev_q;
    logic [FRAME_BITS-1:0] shiftIn_q;
    logic [FRAME_BITS-1:0] shiftOut_q;
    logic [BIT_W-1:0] bitCount_q;
    logic frameGapOk_q;
    logic gapMet;
    logic frameStart;
    logic frameEnd;
    logic sclkRise;
    logic sclkFall;
    logic frameGood;

    assign frameStart = selPrev_q && !select_low_n;
    assign frameEnd = !selPrev_q && select_low_n;
    assign sclkRise = !sclkPrev_q && serialClk && !select_low_n;
    assign sclkFall = sclkPrev_q && !serialClk && !select_low_n;
    assign frameGood = frameEnd && frameGapOk_q && bitCount_q == BIT_W'(FRAME_BITS);

    ssm_gap_timer #(
        .GAP_CYC(GAP_CYC)
    ) u_gap (
        .clk(clk),
        .rst(rst || clearAll_q),
        .selectHigh(select_low_n),
        .gapMet(gapMet)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            selPrev_q <= 1'b1;
        end else begin
            sclkPrev_q <= serialClk;
            selPrev_q <= select_low_n;
        end
    end

    // Frame only counts if the preceding idle gap was long enough
    always_ff @(posedge clk or posedge clearAll_q) begin
        if (clearAll_q) begin
            frameGapOk_q <= 1'b0;
        end else if (frameStart) begin
            frameGapOk_q <= gapMet;
        end
    end

    always_ff @(posedge clk or posedge clearAll_q) begin
        if (clearAll_q) begin
            shiftIn_q <= '0;
            bitCount_q <= '0;
        end else if (frameStart) begin
            bitCount_q <= '0;
        end else if (sclkRise) begin
            shiftIn_q <= {shiftIn_q[FRAME_BITS-2:0], serialIn};
            if (bitCount_q != BIT_W'(FRAME_BITS)) begin
                bitCount_q <= bitCount_q + BIT_W'(1);
            end
        end
    end

    // Status is shifted out MSB first; first bit is ready as the frame opens
    always_ff @(posedge clk or posedge clearAll_q) begin
        if (clearAll_q) begin
            shiftOut_q <= '0;
        end else if (frameStart) begin
            shiftOut_q <= status_q;
        end else if (sclkFall) begin
            shiftOut_q <= {shiftOut_q[FRAME_BITS-2:0], 1'b0};
        end
    end

    // ----------------------------------------
    // Control and status registers
    // ----------------------------------------
    // Motor supply loss is reported in the sticky status but touches no control content
    always_comb begin
        statSet = faultEvent;
        statSet[`SSM_STAT_MOTOR_LOW] = faultEvent[`SSM_STAT_MOTOR_LOW] | !motorSupplyOk;
    end

    always_ff @(posedge clk or posedge clearAll_q) begin
        if (clearAll_q) begin
            ctrl_q <= `SSM_CTRL_RST;
        end else if (frameGood) begin
            ctrl_q <= shiftIn_q[`SSM_CTRL_W-1:0];
        end
    end

    // Sticky faults; a new event in the read-out cycle survives the clear
    always_ff @(posedge clk or posedge clearAll_q) begin
        if (clearAll_q) begin
            status_q <= `SSM_STAT_RST;
        end else if (frameGood) begin
            status_q <= statSet;
        end else begin
            status_q <= status_q | statSet;
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            mode <= SSM_POR;
            gateEnable <= 1'b0;
            chargePumpEn <= 1'b0;
            diagEnable <= 1'b0;
        end else begin
            mode <= mode_d;
            gateEnable <= (mode_d == SSM_ACTIVE) && ctrl_q[`SSM_CTRL_GATE_EN] && supplyValid_q;
            chargePumpEn <= (mode_d == SSM_ACTIVE);
            diagEnable <= (mode_d == SSM_ACTIVE);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cmdAccepted <= 1'b0;
            gapViolation <= 1'b0;
            ctrlWord <= `SSM_CTRL_RST;
            statusWord <= `SSM_STAT_RST;
        end else begin
            cmdAccepted <= frameGood;
            gapViolation <= frameEnd && !frameGapOk_q && !clearAll_q;
            ctrlWord <= ctrl_q;
            statusWord <= status_q;
        end
    end

    // Output enable lags select by one cycle since it comes from a flop
    always_ff @(posedge clk) begin
        if (rst) begin
            serialOut <= 1'b0;
            serialOutOen_n <= 1'b1;
        end else begin
            serialOut <= shiftOut_q[FRAME_BITS-1];
            serialOutOen_n <= select_low_n || clearAll_q;
        end
    end
endmodule

// ==== verif/ssm_mode_ctrl_sva.sv ====
`timescale 1ns/10ps
module ssm_mode_ctrl_sva
    import ssm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Supplies and enable
    input wire logic logicSupplyAboveRelease,
    input wire logic logicSupplyBelowDrop,
    input wire logic motorSupplyOk,
    input wire logic enablePin,
    // Serial link
    input wire logic select_low_n,
    input wire logic serialOutOen_n,
    // Mode and drive
    input wire ssm_pkg::ssm_mode_t mode,
    input wire logic gateEnable,
    input wire logic chargePumpEn,
    input wire logic diagEnable,
    input wire logic cmdAccepted,
    input wire logic gapViolation,
    input wire logic [15:0] ctrlWord,
    input wire logic [15:0] statusWord
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    sequence selIdle;
        select_low_n ##1 select_low_n;
    endsequence
    sequence dropHeld;
        logicSupplyBelowDrop [*5];
    endsequence
    por_hold_a: assert property ($fell(rst) |-> (mode == SSM_POR) [*8])
        else $error("mode left reset hold early");
    drop_clear_a: assert property (dropHeld |-> !gateEnable && statusWord == 16'h0000)
        else $error("supply drop did not clear");
    motor_keep_a: assert property (!motorSupplyOk && mode == SSM_ACTIVE && $past(mode) == SSM_ACTIVE
        && !cmdAccepted && !$past(cmdAccepted) |-> $stable(ctrlWord))
        else $error("control word changed on motor loss");
    enable_low_a: assert property (!enablePin [*3] |-> mode != SSM_ACTIVE)
        else $error("active with enable low");
    standby_off_a: assert property (mode != SSM_ACTIVE && $past(mode) != SSM_ACTIVE
        |-> !gateEnable && !chargePumpEn && !diagEnable && serialOutOen_n)
        else $error("outputs on outside active mode");
    drop_exit_a: assert property (logicSupplyBelowDrop [*3] |-> mode != SSM_ACTIVE)
        else $error("active with supply low");
    pump_on_a: assert property (mode == SSM_ACTIVE ##1 mode == SSM_ACTIVE |-> chargePumpEn && diagEnable)
        else $error("pump or diagnostics off in active mode");
    gap_refuse_a: assert property (gapViolation |-> !cmdAccepted ##1 $stable(ctrlWord))
        else $error("short gap frame accepted");
    oe_idle_a: assert property (selIdle |-> serialOutOen_n)
        else $error("data output driven while deselected");
    accept_active_a: assert property (cmdAccepted |-> mode == SSM_ACTIVE && select_low_n)
        else $error("command accepted outside active mode");
endmodule

bind ssm_mode_ctrl ssm_mode_ctrl_sva ssm_mode_ctrl_sva_inst (.clk(clk), .rst(rst),
    .logicSupplyAboveRelease(logicSupplyAboveRelease), .logicSupplyBelowDrop(logicSupplyBelowDrop),
    .motorSupplyOk(motorSupplyOk), .enablePin(enablePin), .select_low_n(select_low_n),
    .serialOutOen_n(serialOutOen_n), .mode(mode), .gateEnable(gateEnable), .chargePumpEn(chargePumpEn),
    .diagEnable(diagEnable), .cmdAccepted(cmdAccepted), .gapViolation(gapViolation),
    .ctrlWord(ctrlWord), .statusWord(statusWord));

// ==== verif/ssm_host_model.sv ====
`timescale 1ns/10ps
module ssm_host_model (
    // Clock
    input wire logic clk,
    // Frame request
    input wire logic start,
    input wire logic [15:0] txData,
    input wire logic [4:0] nBits,
    input wire logic [3:0] halfCyc,
    input wire logic [7:0] gapCyc,
    output logic busy = 1'h0,
    output logic [15:0] rxData = 16'h0000,
    // Serial link
    output logic select_low_n = 1'h1,
    output logic serialClk = 1'h0,
    output logic serialIn = 1'h0,
    input wire logic serialOut
);
    // Serial clock stands still low outside frames
    initial begin
        forever begin
            @(posedge clk);
            if (start) begin
                busy <= 1'h1;
                select_low_n <= 1'h0;
                repeat (3) @(posedge clk);
                for (int i = 0; i < nBits; i++) begin
                    serialIn <= txData[15 - i];
                    repeat (halfCyc) @(posedge clk);
                    rxData <= {rxData[14:0], serialOut};
                    serialClk <= 1'h1;
                    repeat (halfCyc) @(posedge clk);
                    serialClk <= 1'h0;
                end
                repeat (2) @(posedge clk);
                select_low_n <= 1'h1;
                // Released line shows the inverse, never a stale level
                serialIn <= ~serialIn;
                repeat (gapCyc) @(posedge clk);
                busy <= 1'h0;
            end
        end
    end
endmodule

// ==== verif/ssm_mode_ctrl_tb.sv ====
`timescale 1ns/10ps
`include "ssm_consts.svh"
module ssm_mode_ctrl_tb;
    import ssm_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic supUp = 1'h1;
    logic supDrop = 1'h0;
    logic motorOk = 1'h1;
    logic enablePin = 1'h0;
    logic [15:0] faultEvent = 16'h0000;
    logic start = 1'h0;
    logic [15:0] txData = 16'h0000;
    logic [4:0] nBits = 5'h10;
    logic [3:0] halfCyc = 4'h4;
    logic [7:0] gapCyc = 8'h28;
    logic busy, selN, sClk, sIn, sOut, sOen, gateEnable, chargePumpEn, diagEnable, acc, gapBad;
    logic [15:0] rxData, ctrlWord, statusWord, expCtrl, expStat;
    ssm_mode_t mode;
    logic [31:0] seed = 32'h810E60DC;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    int nAcc = 0;
    int nGap = 0;
    ssm_mode_ctrl ssm_mode_ctrl_inst (.clk(clk), .rst(rst), .logicSupplyAboveRelease(supUp),
        .logicSupplyBelowDrop(supDrop), .motorSupplyOk(motorOk), .enablePin(enablePin), .select_low_n(selN),
        .serialClk(sClk), .serialIn(sIn), .serialOut(sOut), .serialOutOen_n(sOen), .faultEvent(faultEvent),
        .mode(mode), .gateEnable(gateEnable), .chargePumpEn(chargePumpEn), .diagEnable(diagEnable),
        .cmdAccepted(acc), .gapViolation(gapBad), .ctrlWord(ctrlWord), .statusWord(statusWord));
    ssm_host_model ssm_host_model_inst (.clk(clk), .start(start), .txData(txData), .nBits(nBits),
        .halfCyc(halfCyc), .gapCyc(gapCyc), .busy(busy), .rxData(rxData), .select_low_n(selN),
        .serialClk(sClk), .serialIn(sIn), .serialOut(sOen ? ~sOut : sOut));
    initial begin
        forever #25 clk = ~clk;
    end
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic frame(input logic [15:0] d, input logic [4:0] n, input logic [7:0] g);
        @(posedge clk);
        txData <= d;
        nBits <= n;
        gapCyc <= g;
        start <= 1'h1;
        @(posedge clk);
        while (busy !== 1'h1) @(posedge clk);
        start <= 1'h0;
        while (busy === 1'h1) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic good(input logic [15:0] d);
        frame(d, 5'h10, 8'h28);
        expCtrl = d;
        chk(ctrlWord, expCtrl);
        chk({15'h0000, gateEnable}, {15'h0000, d[`SSM_CTRL_GATE_EN]});
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        nAcc <= nAcc + int'(acc === 1'h1);
        nGap <= nGap + int'(gapBad === 1'h1);
        if (cycles == 20000) begin
            num_errors++;
            final_report();
        end
    end
    initial begin
        wt(20);
        rst <= 1'h0;
        @(negedge clk);
        chk(16'(mode), 16'(SSM_POR));
        wt(30);
        @(negedge clk);
        chk(16'(mode), 16'(SSM_STANDBY));
        chk({15'h0000, chargePumpEn}, 16'h0000);
        @(posedge clk);
        enablePin <= 1'h1;
        seed = xorshift(seed);
        faultEvent <= seed[31:16];
        expStat = seed[31:16];
        wt(5);
        faultEvent <= 16'h0000;
        @(negedge clk);
        chk(16'(mode), 16'(SSM_ACTIVE));
        chk({14'h0000, chargePumpEn, diagEnable}, 16'h0003);
        wt(45);
        good(16'h8001);
        chk(rxData, expStat);
        for (int i = 0; i < 4; i++) begin
            seed = xorshift(seed);
            halfCyc <= seed[0] ? 4'h9 : 4'h4;
            good(seed[31:16]);
        end
        chk(rxData, 16'h0000);
        frame(seed[15:0], 5'hF, 8'h28);
        chk(ctrlWord, expCtrl);
        good(~expCtrl);
        frame(16'hFFFF, 5'h10, 8'h02);
        expCtrl = 16'hFFFF;
        chk(ctrlWord, expCtrl);
        frame(16'h0F0F, 5'h10, 8'h28);
        chk(ctrlWord, expCtrl);
        chk(16'(nGap), 16'h0001);
        motorOk <= 1'h0;
        wt(10);
        @(negedge clk);
        chk(ctrlWord, expCtrl);
        @(posedge clk);
        motorOk <= 1'h1;
        enablePin <= 1'h0;
        wt(4);
        @(negedge clk);
        chk({ctrlWord[15:1], gateEnable}, `SSM_CTRL_RST);
        chk(statusWord, 16'h0000);
        @(posedge clk);
        enablePin <= 1'h1;
        wt(45);
        good(16'h0001);
        supDrop <= 1'h1;
        wt(6);
        @(negedge clk);
        chk({statusWord[15:1], gateEnable}, 16'h0000);
        @(posedge clk);
        supDrop <= 1'h0;
        rst <= 1'h1;
        wt(3);
        rst <= 1'h0;
        wt(30);
        @(negedge clk);
        chk(16'(mode), 16'(SSM_ACTIVE));
        wt(45);
        good(16'h7FFE);
        chk(16'(nAcc), 16'h0009);
        final_report();
    end
endmodule
